// >>> shared/sdc_map.svh
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
`define SDC_FIXED_CLOCK_HZ 27000000
`define SDC_CFG_CLK_NS 37
`define SDC_PLL_LOCK_WAIT_NS 2000000
`define SDC_RESET_WAIT_NS 500000
`define SDC_WAIT_COUNTER_WIDTH 16
`define SDC_RETRY_COUNTER_WIDTH 8
`define SDC_SEL_CHANNEL 2'b00
`define SDC_SEL_SHARED 2'b11
`define SDC_ERRCNT_WIDTH 16
`define SDC_FAM_274 4'h0
`define SDC_FAM_720 4'h1
`define SDC_FAM_2048 4'h2
`define SDC_FAM_295 4'h3
`define SDC_FAM_NTSC 4'h8
`define SDC_FAM_PAL 4'h9
`define SDC_FAM_UNKNOWN 4'hf
`define SDC_RATE_NONE 4'h0
`define SDC_RATE_2398 4'h2
`define SDC_RATE_24 4'h3
`define SDC_RATE_4795 4'h4
`define SDC_RATE_25 4'h5
`define SDC_RATE_2997 4'h6
`define SDC_RATE_30 4'h7
`define SDC_RATE_48 4'h8
`define SDC_RATE_50 4'h9
`define SDC_RATE_5994 4'ha
`define SDC_RATE_60 4'hb
`define SDC_APB_CTRL 12'h000
`define SDC_APB_STATUS 12'h004
`define SDC_APB_FORMAT 12'h008
`define SDC_APB_ERRCNT 12'h00c
`define SDC_APB_ERRMASK 12'h010
`define SDC_APB_RETRIES 12'h014
`define SDC_ERRMASK_RESET 16'hffff
`endif

// >>> shared/sdc_pkg.sv
package sdc_pkg;
   typedef enum logic [2:0] {
      SDC_IDLE = 3'b000,
      SDC_PLL_RST = 3'b001,
      SDC_PLL_WAIT = 3'b010,
      SDC_GT_RST = 3'b011,
      SDC_GT_WAIT = 3'b100,
      SDC_DONE = 3'b101,
      SDC_FAIL = 3'b110
   } sdc_seq_e;
   typedef logic [1:0] sdc_vmode_t;
endpackage

// >>> core/sdc_init_seq.sv
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_init_seq
   import sdc_pkg::*;
#(
   parameter int pll_lock_wait_ns = `SDC_PLL_LOCK_WAIT_NS,
   parameter int reset_wait_ns = `SDC_RESET_WAIT_NS,
   parameter int cfg_clk_ns = `SDC_CFG_CLK_NS,
   parameter int wait_counter_width = `SDC_WAIT_COUNTER_WIDTH,
   parameter int retry_counter_width = `SDC_RETRY_COUNTER_WIDTH
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic pll_lock,
   input wire logic reset_done,
   output logic pll_reset,
   output logic gt_reset,
   output logic done,
   output logic fail,
   output logic [retry_counter_width-1:0] retries
);
   // waits counted in config periods
   // terminal counts, truncated so none exceeds the wait, except a wait under one period, which gets 1
   localparam int PLL_TC_I = (pll_lock_wait_ns / cfg_clk_ns) < 1 ? 1 :
      pll_lock_wait_ns / cfg_clk_ns;
   localparam int RST_TC_I = (reset_wait_ns / cfg_clk_ns) < 1 ? 1 :
      reset_wait_ns / cfg_clk_ns;
   localparam logic [wait_counter_width-1:0] PLL_TC =
      PLL_TC_I[wait_counter_width-1:0];
   localparam logic [wait_counter_width-1:0] RST_TC =
      RST_TC_I[wait_counter_width-1:0];
   localparam logic [retry_counter_width-1:0] RETRY_MAX = '1;

   sdc_seq_e state_q;
   logic [wait_counter_width-1:0] wait_q;
   logic [retry_counter_width-1:0] retry_q;
   wire pll_timeout = (wait_q == PLL_TC);
   wire gt_timeout = (wait_q == RST_TC);
   wire give_up = (retry_q == RETRY_MAX);
   // first wait cycle still sees pre-reset lock or done
   wire settled = (wait_q != '0);

   assign pll_reset = (state_q == SDC_PLL_RST);
   assign gt_reset = (state_q == SDC_GT_RST);
   assign done = (state_q == SDC_DONE);
   assign fail = (state_q == SDC_FAIL);
   assign retries = retry_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= SDC_IDLE;
         wait_q <= '0;
         retry_q <= '0;
      end
      else if (start)
      begin
         state_q <= SDC_PLL_RST;
         wait_q <= '0;
         retry_q <= '0;
      end
      else
      begin
         case (state_q)
            SDC_PLL_RST:
            begin
               wait_q <= '0;
               state_q <= SDC_PLL_WAIT;
            end
            SDC_PLL_WAIT:
            begin
               wait_q <= wait_q + 1'b1;
               if (pll_lock && settled)
                  state_q <= SDC_GT_RST;
               else if (pll_timeout)
               begin
                  if (give_up)
                     state_q <= SDC_FAIL;
                  else
                  begin
                     retry_q <= retry_q + 1'b1;
                     state_q <= SDC_PLL_RST;
                  end
               end
            end
            SDC_GT_RST:
            begin
               wait_q <= '0;
               state_q <= SDC_GT_WAIT;
            end
            SDC_GT_WAIT:
            begin
               wait_q <= wait_q + 1'b1;
               if (reset_done && settled)
                  state_q <= SDC_DONE;
               else if (gt_timeout)
               begin
                  if (give_up)
                     state_q <= SDC_FAIL;
                  else
                  begin
                     retry_q <= retry_q + 1'b1;
                     state_q <= SDC_GT_RST;
                  end
               end
            end
            SDC_IDLE, SDC_DONE, SDC_FAIL:
               state_q <= state_q;
            default:
               state_q <= SDC_IDLE;
         endcase
      end
   end
endmodule

// >>> core/sdc_top.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_top
   import sdc_pkg::*;
#(
   parameter int fixed_clock_hz = `SDC_FIXED_CLOCK_HZ,
   parameter int cfg_clk_ns = `SDC_CFG_CLK_NS,
   parameter int pll_lock_wait_ns = `SDC_PLL_LOCK_WAIT_NS,
   parameter int reset_wait_ns = `SDC_RESET_WAIT_NS,
   parameter int wait_counter_width = `SDC_WAIT_COUNTER_WIDTH,
   parameter int retry_counter_width = `SDC_RETRY_COUNTER_WIDTH,
   parameter bit tx_source0_is_shared = 1'b1,
   parameter bit tx_source1_is_shared = 1'b0,
   parameter bit rx_source_is_shared = 1'b1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_rate_sel,
   input wire logic [1:0] tx_video_mode,
   input wire logic [1:0] rx_video_mode,
   input wire logic pll_lock,
   input wire logic reset_done,
   output logic pll_reset,
   output logic gt_reset,
   output logic [1:0] tx_pll_sel,
   output logic [2:0] tx_clk_div,
   output logic [2:0] rx_clk_div,
   input wire logic rx_locked,
   input wire logic rx_sav,
   input wire logic rx_eav,
   input wire logic rx_field,
   input wire logic rx_vblank,
   input wire logic field_end,
   input wire logic [15:0] field_errors,
   output logic [3:0] rx_family,
   output logic rx_interlaced,
   output logic [3:0] rx_frame_rate,
   output logic [15:0] err_count
);
   localparam int FIX_CYC_PER_MS = fixed_clock_hz / 1000;

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   logic [15:0] err_mask_q;
   logic start_q;
   logic clr_q;
   logic seq_done, seq_fail;
   logic [retry_counter_width-1:0] seq_retries;
   logic [15:0] err_cnt_q;
   wire wr_access = psel & penable & pwrite;
   wire hit_ctrl = (paddr == `SDC_APB_CTRL);
   wire hit_status = (paddr == `SDC_APB_STATUS);
   wire hit_format = (paddr == `SDC_APB_FORMAT);
   wire hit_errcnt = (paddr == `SDC_APB_ERRCNT);
   wire hit_mask = (paddr == `SDC_APB_ERRMASK);
   wire hit_retry = (paddr == `SDC_APB_RETRIES);
   wire hit_any = hit_ctrl | hit_status | hit_format | hit_errcnt |
      hit_mask | hit_retry;
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = 32'h0;
      if (hit_status)
         rd_mux = {30'h0, seq_fail, seq_done};
      else if (hit_format)
         rd_mux = {23'h0, rx_interlaced, rx_frame_rate, rx_family};
      else if (hit_errcnt)
         rd_mux = {16'h0, err_cnt_q};
      else if (hit_mask)
         rd_mux = {16'h0, err_mask_q};
      else if (hit_retry)
         rd_mux = 32'({seq_retries});
   end

   // one wait state: answer in second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit_any;
         if (psel & penable & ~pready)
            prdata <= pwrite ? 32'h0 : rd_mux;
      end
   end

   wire wr_take = wr_access & pready;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_mask_q <= `SDC_ERRMASK_RESET;
         start_q <= 1'b0;
         clr_q <= 1'b0;
      end
      else
      begin
         if (wr_take & hit_mask)
            err_mask_q <= pwdata[15:0];
         start_q <= wr_take & hit_ctrl & pwdata[0];
         clr_q <= wr_take & hit_ctrl & pwdata[1];
      end
   end

   // ------------------------------------------------------------
   // transceiver reset sequencing
   // ------------------------------------------------------------
   logic seq_pll_rst, seq_gt_rst;
   sdc_init_seq #(
      .pll_lock_wait_ns(pll_lock_wait_ns),
      .reset_wait_ns(reset_wait_ns),
      .cfg_clk_ns(cfg_clk_ns),
      .wait_counter_width(wait_counter_width),
      .retry_counter_width(retry_counter_width)
   ) u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .start(start_q),
      .pll_lock(pll_lock),
      .reset_done(reset_done),
      .pll_reset(seq_pll_rst),
      .gt_reset(seq_gt_rst),
      .done(seq_done),
      .fail(seq_fail),
      .retries(seq_retries)
   );

   // ------------------------------------------------------------
   // pll selection and dividers
   // ------------------------------------------------------------
   function automatic logic [2:0] div_sel(input logic shared,
      input sdc_vmode_t mode);
      logic [2:0] base;
      base = shared ? 3'h1 : 3'h2;
      case (mode)
         2'b00: div_sel = base + 3'h2;
         2'b01: div_sel = base + 3'h1;
         default: div_sel = base;
      endcase
   endfunction

   wire tx_shared = tx_rate_sel ? tx_source1_is_shared :
      tx_source0_is_shared;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_pll_sel <= `SDC_SEL_CHANNEL;
         tx_clk_div <= 3'h0;
         rx_clk_div <= 3'h0;
         pll_reset <= 1'b0;
         gt_reset <= 1'b0;
      end
      else
      begin
         tx_pll_sel <= tx_shared ? `SDC_SEL_SHARED : `SDC_SEL_CHANNEL;
         tx_clk_div <= div_sel(tx_shared, tx_video_mode);
         rx_clk_div <= div_sel(rx_source_is_shared, rx_video_mode);
         pll_reset <= seq_pll_rst;
         gt_reset <= seq_gt_rst;
      end
   end

   // ------------------------------------------------------------
   // transport detector
   // ------------------------------------------------------------
   logic [12:0] line_len_q, line_cnt_q;
   logic [10:0] lines_q, line_no_q;
   logic [23:0] frame_cyc_q, frame_cnt_q;
   logic [1:0] frames_q;
   logic field_q;
   logic saw_field1_q;
   logic eav_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         line_cnt_q <= 13'h0;
         line_len_q <= 13'h0;
         line_no_q <= 11'h0;
         lines_q <= 11'h0;
         frame_cnt_q <= 24'h0;
         frame_cyc_q <= 24'h0;
         frames_q <= 2'h0;
         field_q <= 1'b0;
         saw_field1_q <= 1'b0;
         eav_q <= 1'b0;
      end
      else if (!rx_locked)
      begin
         frames_q <= 2'h0;
         saw_field1_q <= 1'b0;
         line_cnt_q <= 13'h0;
      end
      else
      begin
         eav_q <= rx_eav;
         field_q <= rx_field;
         line_cnt_q <= rx_sav ? 13'h0 : line_cnt_q + 13'h1;
         frame_cnt_q <= frame_cnt_q + 24'h1;
         if (rx_sav & ~rx_vblank)
            line_len_q <= line_cnt_q;
         if (eav_q)
            line_no_q <= line_no_q + 11'h1;
         if (rx_field)
            saw_field1_q <= 1'b1;
         if (field_q & ~rx_field)
         begin
            lines_q <= line_no_q;
            line_no_q <= 11'h0;
            frame_cyc_q <= frame_cnt_q;
            frame_cnt_q <= 24'h0;
            if (frames_q != 2'h2)
               frames_q <= frames_q + 2'h1;
         end
      end
   end

   wire fmt_valid = (frames_q == 2'h2);
   // whole frame period in pclk cycles
   wire [23:0] fcyc = frame_cyc_q;
   function automatic logic [3:0] rate_code(input logic [23:0] cyc);
      if (cyc > 24'd5100000)
         rate_code = cyc > 24'd5210000 ? `SDC_RATE_2398 : `SDC_RATE_24;
      else if (cyc > 24'd4500000)
         rate_code = `SDC_RATE_25;
      else if (cyc > 24'd4160000)
         rate_code = cyc > 24'd4168000 ? `SDC_RATE_2997 : `SDC_RATE_30;
      else if (cyc > 24'd2550000)
         rate_code = cyc > 24'd2605000 ? `SDC_RATE_4795 : `SDC_RATE_48;
      else if (cyc > 24'd2250000)
         rate_code = `SDC_RATE_50;
      else if (cyc > 24'd1000000)
         rate_code = cyc > 24'd2084000 ? `SDC_RATE_5994 : `SDC_RATE_60;
      else
         rate_code = `SDC_RATE_NONE;
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_family <= `SDC_FAM_UNKNOWN;
         rx_interlaced <= 1'b0;
         rx_frame_rate <= `SDC_RATE_NONE;
      end
      else if (!fmt_valid)
      begin
         rx_family <= `SDC_FAM_UNKNOWN;
         rx_frame_rate <= `SDC_RATE_NONE;
      end
      else
      begin
         rx_interlaced <= saw_field1_q;
         rx_frame_rate <= rate_code(fcyc);
         if (line_len_q > 13'd2000)
            rx_family <= `SDC_FAM_2048;
         else if (lines_q > 11'd1100 && lines_q < 11'd1130)
            rx_family <= `SDC_FAM_274;
         else if (lines_q >= 11'd1245)
            rx_family <= `SDC_FAM_295;
         else if (lines_q > 11'd740 && lines_q < 11'd760)
            rx_family <= `SDC_FAM_720;
         else if (lines_q > 11'd520 && lines_q < 11'd530)
            rx_family <= `SDC_FAM_NTSC;
         else if (lines_q > 11'd620 && lines_q < 11'd630)
            rx_family <= `SDC_FAM_PAL;
         else
            rx_family <= `SDC_FAM_UNKNOWN;
      end
   end

   // ------------------------------------------------------------
   // errored field counter
   // ------------------------------------------------------------
   // bit layout anc 0-4, ff 5-9, ap 10-14, pkt 15
   wire any_err = |(field_errors & err_mask_q);
   wire cnt_full = (err_cnt_q == 16'hffff);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         err_cnt_q <= 16'h0;
      else if (clr_q)
         err_cnt_q <= 16'h0;
      else if (field_end & any_err & ~cnt_full)
         err_cnt_q <= err_cnt_q + 16'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         err_count <= 16'h0;
      else
         err_count <= err_cnt_q;
   end
endmodule

// >>> testbench/sdc_asserts.sv
`timescale 1ns/1ps
module sdc_asserts
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_rate_sel,
   input wire logic [1:0] tx_video_mode,
   input wire logic [1:0] rx_video_mode,
   input wire logic pll_lock,
   input wire logic pll_reset,
   input wire logic gt_reset,
   input wire logic [1:0] tx_pll_sel,
   input wire logic [2:0] tx_clk_div,
   input wire logic [2:0] rx_clk_div,
   input wire logic field_end,
   input wire logic [15:0] err_count
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // -------------------------------
   // divider expectation, default sources
   // -------------------------------
   function automatic logic [2:0] div(input logic sh, input logic [1:0] m);
      return (sh ? 3'h1 : 3'h2) + (m[1] ? 3'h0 : (m[0] ? 3'h1 : 3'h2));
   endfunction
   property p_sel_codes;
      tx_pll_sel == 2'b00 || tx_pll_sel == 2'b11;
   endproperty
   a_sel_codes: assert property (p_sel_codes)
      else $error("pll select code out of set");
   property p_sel_follow;
      $past(presetn) && $stable(tx_rate_sel)
         |=> tx_pll_sel == ($past(tx_rate_sel) ? 2'b00 : 2'b11);
   endproperty
   a_sel_follow: assert property (p_sel_follow)
      else $error("pll select ignores rate select");
   property p_tx_div;
      $past(presetn) && $stable(tx_rate_sel) && $stable(tx_video_mode)
         |=> tx_clk_div == div(!$past(tx_rate_sel), $past(tx_video_mode));
   endproperty
   a_tx_div: assert property (p_tx_div)
      else $error("tx divider wrong");
   property p_rx_div;
      $past(presetn) && $stable(rx_video_mode)
         |=> rx_clk_div == div(1'b1, $past(rx_video_mode));
   endproperty
   a_rx_div: assert property (p_rx_div)
      else $error("rx divider wrong");
   property p_ready_time;
      psel && $rose(penable) |=> pready;
   endproperty
   a_ready_time: assert property (p_ready_time)
      else $error("bus answer late");
   property p_slverr;
      pslverr |-> pready;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("error without ready");
   property p_pll_quiet;
      pll_reset |=> (!pll_reset)[*8];
   endproperty
   a_pll_quiet: assert property (p_pll_quiet)
      else $error("pll retried before timeout");
   property p_gt_order;
      gt_reset |-> pll_lock;
   endproperty
   a_gt_order: assert property (p_gt_order)
      else $error("transceiver reset without lock");
   property p_cnt_step;
      $changed(err_count) |-> err_count == $past(err_count) + 16'h1
         || err_count == 16'h0;
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("count jumped");
   property p_cnt_cause;
      err_count == $past(err_count) + 16'h1 |-> $past(field_end, 2);
   endproperty
   a_cnt_cause: assert property (p_cnt_cause)
      else $error("count rose without field end");
   cover property (pslverr);
   cover property ($rose(gt_reset));
   cover property (err_count == 16'h0011);
endmodule
bind sdc_top sdc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready,
   .pslverr, .tx_rate_sel, .tx_video_mode, .rx_video_mode, .pll_lock,
   .pll_reset, .gt_reset, .tx_pll_sel, .tx_clk_div, .rx_clk_div,
   .field_end, .err_count);

// >>> testbench/sdc_xcvr_model.sv
`timescale 1ns/1ps
module sdc_xcvr_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pll_reset,
   input wire logic gt_reset,
   input wire logic [9:0] lock_delay,
   input wire logic [9:0] done_delay,
   output logic pll_lock,
   output logic reset_done
);
   logic [9:0] lock_q;
   logic [9:0] done_q;
   // -------------------------------
   // lock and done after set delays
   // -------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lock_q <= 10'h0;
         done_q <= 10'h0;
      end
      else
      begin
         lock_q <= pll_reset ? 10'h0 : lock_q + {9'h0, lock_q != 10'h3ff};
         done_q <= (pll_reset || gt_reset) ? 10'h0
            : done_q + {9'h0, done_q != 10'h3ff};
      end
   end
   assign pll_lock = lock_q >= lock_delay;
   assign reset_done = done_q >= done_delay;
endmodule

// >>> testbench/sdc_top_tb.sv
`timescale 1ns/1ps
`include "sdc_map.svh"
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         n_mismatch++; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end
module sdc_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic tx_rate_sel, pll_lock, reset_done, pll_reset, gt_reset;
   logic [1:0] tx_video_mode, rx_video_mode, tx_pll_sel;
   logic [2:0] tx_clk_div, rx_clk_div;
   logic field_end, rx_interlaced, e;
   logic rx_locked, rx_sav, rx_eav, rx_field, rx_vblank;
   logic [15:0] field_errors, err_count;
   logic [3:0] rx_family, rx_frame_rate;
   logic [9:0] lock_delay, done_delay;
   int checked, n_mismatch, cyc, n_pll, n_gt;
   sdc_top #(.pll_lock_wait_ns(370), .reset_wait_ns(185),
      .retry_counter_width(2)) DUT (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_rate_sel,
      .tx_video_mode, .rx_video_mode, .pll_lock, .reset_done, .pll_reset,
      .gt_reset, .tx_pll_sel, .tx_clk_div, .rx_clk_div,
      .rx_locked, .rx_sav, .rx_eav, .rx_field,
      .rx_vblank, .field_end, .field_errors, .rx_family,
      .rx_interlaced, .rx_frame_rate, .err_count);
   sdc_xcvr_model u_xcvr (.pclk, .presetn, .pll_reset, .gt_reset,
      .lock_delay, .done_delay, .pll_lock, .reset_done);
   always #4 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      n_pll += (pll_reset === 1'b1);
      n_gt += (gt_reset === 1'b1);
      if (cyc == 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic rst;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      n_pll = 0;
      n_gt = 0;
      @(posedge pclk);
   endtask
   // -------------------------------
   // bus cycle, held until pready
   // -------------------------------
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic fld(input logic [15:0] f);
      field_errors <= f;
      field_end <= 1'b1;
      @(posedge pclk);
      field_end <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // -------------------------------
   // video lines, four cycles each
   // -------------------------------
   task automatic frm(input int n);
      for (int l = 0; l < n; l++)
      begin
         rx_field <= (l >= 262);
         rx_vblank <= (l < 9);
         rx_eav <= 1'b1;
         @(posedge pclk);
         rx_eav <= 1'b0;
         @(posedge pclk);
         rx_sav <= 1'b1;
         @(posedge pclk);
         rx_sav <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic seq(input logic [9:0] ld, input logic [9:0] dd);
      lock_delay <= ld;
      done_delay <= dd;
      rst();
      apb(1'b1, `SDC_APB_CTRL, 32'h1);
      d = 32'h0;
      for (int i = 0; i < 400 && d[1:0] == 2'b00; i++)
         apb(1'b0, `SDC_APB_STATUS, 32'h0);
   endtask
   initial
   begin
      pclk = 1'b0;
      {presetn, psel, penable, pwrite, tx_rate_sel, field_end} = 6'h0;
      {paddr, pwdata, field_errors} = 60'h0;
      {tx_video_mode, rx_video_mode} = 4'h0;
      {rx_locked, rx_sav, rx_eav, rx_field, rx_vblank} = 5'h0;
      lock_delay = 10'h3;
      done_delay = 10'h2;
      rst();
      `CHK("family", 4'hf, rx_family)
      `CHK("rate", 4'h0, rx_frame_rate)
      apb(1'b0, `SDC_APB_FORMAT, 32'h0);
      `CHK("format", 32'h0000000f, d)
      apb(1'b0, `SDC_APB_ERRMASK, 32'h0);
      `CHK("mask", 32'h0000ffff, d)
      apb(1'b0, 12'hff0, 32'h0);
      `CHK("unmapped", 33'h100000000, {e, d})
      $display("test reset values done");
      for (int s = 0; s < 2; s++)
         for (int m = 0; m < 3; m++)
         begin
            tx_rate_sel <= s[0];
            tx_video_mode <= m[1:0];
            rx_video_mode <= m[1:0];
            repeat (4) @(posedge pclk);
            `CHK("pll_sel", s ? 2'b00 : 2'b11, tx_pll_sel)
            `CHK("tx_div", 3'(s + 3 - m), tx_clk_div)
            `CHK("rx_div", 3'(3 - m), rx_clk_div)
         end
      $display("test clock select done");
      seq(10'h3, 10'h2);
      `CHK("seq_ok", 32'h1, d)
      `CHK("pll_pulses", 1, n_pll)
      seq(10'h3ff, 10'h2);
      `CHK("seq_lock_fail", 32'h2, d)
      `CHK("pll_tries", 4, n_pll)
      apb(1'b0, `SDC_APB_RETRIES, 32'h0);
      `CHK("retries", 32'h3, d)
      seq(10'h3, 10'h3ff);
      `CHK("seq_done_fail", 32'h2, d)
      `CHK("gt_tries", 4, n_gt)
      $display("test sequencer done");
      rst();
      apb(1'b1, `SDC_APB_ERRMASK, 32'h8001);
      fld(16'h0002);
      `CHK("masked", 16'h0, err_count)
      fld(16'h8001);
      `CHK("one_per_field", 16'h1, err_count)
      apb(1'b1, `SDC_APB_ERRMASK, 32'hffff);
      for (int i = 0; i < 16; i++)
         fld(16'h1 << i);
      apb(1'b0, `SDC_APB_ERRCNT, 32'h0);
      `CHK("errcnt_reg", 32'h11, d)
      `CHK("errcnt", 16'h11, err_count)
      apb(1'b1, `SDC_APB_CTRL, 32'h2);
      repeat (3) @(posedge pclk);
      `CHK("cleared", 16'h0, err_count)
      $display("test error count done");
      rx_locked <= 1'b1;
      frm(525);
      frm(525);
      `CHK("fam_early", 4'hf, rx_family)
      frm(1);
      `CHK("family_ntsc", 4'h8, rx_family)
      `CHK("interlaced", 1'b1, rx_interlaced)
      `CHK("rate_none", 4'h0, rx_frame_rate)
      apb(1'b0, `SDC_APB_FORMAT, 32'h0);
      `CHK("format_ntsc", 32'h00000108, d)
      rx_locked <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("fam_unlocked", 4'hf, rx_family)
      $display("test transport detector done");
      end_sim();
   end
endmodule
